// ===== core/sfx_engine.sv
// SPI transfer engine: queues, frame counting, error flags, DMA requests,
//   APB register slave, master-mode shifter.
// Assumes pclk at 125 MHz, presetn asynchronous active low, the slave's
//   data input arriving from outside the clock domain.
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/100ps

// Notes on behaviour
// - two queues, four deep, 32 wide
// - full and empty flags readable always
// - burst-sent only after all burst frames
// - frame count resets to one
// - empty queue need raises starve, idles
// - full receive queue spills, frame dropped
// - shift exactly frame-width bits per frame
// - count frames, go idle at end, enable stays set
// - frames-sent flag bit 0 and interrupt
// - receive-ready request while data waits
// - transmit-space request when done, space
// - all causes merge onto one interrupt
// - width write ignored while enabled, max 32
module sfx_engine
  import sfx_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // SPI pins
  output logic             spi_clk,
  output logic             spi_do,
  output logic             spi_doe_n,
  input  wire logic        spi_di,
  output logic             target_select_line,
  // DMA and interrupt
  output logic             dma_tx_space_req,
  output logic             dma_rx_ready_req,
  output logic             fabric_irq_link
);

  // ----------------------------------------
  // Registers and decode
  // ----------------------------------------
  logic [31:0] control;          // Control word
  logic [5:0]  frame_bit_width;  // Bits per frame, from one
  logic [7:0]  clk_gen;          // Half-period divider
  logic        slave_sel;        // Target select request
  logic [3:0]  raw_irq_status;   // Sticky events
  logic [3:0]  irq_set;          // Event pulses this cycle
  logic        wr_en;            // APB write access phase
  logic        rd_en;            // APB read access phase
  logic [15:0] frames_per_transfer;

  // Register hit for a given offset
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign pready = 1'b1;
  assign frames_per_transfer = control[CTL_CNT_LO +: 16];

  // ----------------------------------------
  // Queues
  // ----------------------------------------
  // two flip-flop queues
  logic [QWIDTH-1:0] txq [QDEPTH];
  logic [QWIDTH-1:0] rxq [QDEPTH];
  logic [2:0] tx_wp, tx_rp, rx_wp, rx_rp;
  logic tx_queue_full, tx_queue_empty, rx_queue_full, rx_queue_empty;
  logic tx_push, tx_pop, rx_push, rx_pop;
  logic [31:0] rx_word;          // Frame captured by shifter
  logic rx_done;                 // Frame capture complete pulse

  assign tx_queue_empty = (tx_wp == tx_rp);
  assign tx_queue_full  = (tx_wp[1:0] == tx_rp[1:0]) && (tx_wp[2] != tx_rp[2]);
  assign rx_queue_empty = (rx_wp == rx_rp);
  assign rx_queue_full  = (rx_wp[1:0] == rx_rp[1:0]) && (rx_wp[2] != rx_rp[2]);

  // Writes to a full queue are dropped rather than overwrite data
  assign tx_push = wr_en & hit(paddr, OFS_TX_DATA) & ~tx_queue_full;
  assign rx_pop  = rd_en & hit(paddr, OFS_RX_DATA) & ~rx_queue_empty;
  // a frame meeting a full queue is dropped
  assign rx_push = rx_done & ~rx_queue_full;

  // Transmit queue storage and pointers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_wp <= 3'h0;
      tx_rp <= 3'h0;
    end
    else
    begin
      if (tx_push)
      begin
        txq[tx_wp[1:0]] <= pwdata;
        tx_wp           <= tx_wp + 3'h1;
      end
      if (tx_pop)
        tx_rp <= tx_rp + 3'h1;
    end
  end

  // Receive queue storage and pointers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_wp <= 3'h0;
      rx_rp <= 3'h0;
    end
    else
    begin
      if (rx_push)
      begin
        rxq[rx_wp[1:0]] <= rx_word;
        rx_wp           <= rx_wp + 3'h1;
      end
      if (rx_pop)
        rx_rp <= rx_rp + 3'h1;
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      control         <= {8'h00, RST_FRAME_COUNT, 6'h00, RST_MODE, 1'b0};
      frame_bit_width <= RST_FRAME_WIDTH;
      clk_gen         <= RST_CLK_GEN;
      slave_sel       <= 1'b0;
    end
    else if (wr_en)
    begin
      if (hit(paddr, OFS_CONTROL))
        control <= pwdata;
      // ignored while enabled, zero and above 32 refused
      if (hit(paddr, OFS_FRAMESIZE) && !control[CTL_ENABLE] &&
          pwdata[5:0] != 6'h00 && pwdata[5:0] <= MAX_FRAME_WIDTH)
        frame_bit_width <= pwdata[5:0];
      if (hit(paddr, OFS_CLK_GEN))
        clk_gen <= pwdata[7:0];
      if (hit(paddr, OFS_SLAVE_SEL))
        slave_sel <= pwdata[0];
    end
  end

  // ----------------------------------------
  // Link input synchroniser
  // ----------------------------------------
  logic di_meta, di_sync;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      di_meta <= 1'b0;
      di_sync <= 1'b0;
    end
    else
    begin
      di_meta <= spi_di;
      di_sync <= di_meta;
    end
  end

  // ----------------------------------------
  // Master shifter
  // ----------------------------------------
  sfx_state_t  state;
  logic [31:0] shreg;            // Outgoing frame
  logic [5:0]  bit_cnt;          // Bits left in frame
  logic [15:0] frame_cnt;        // Frames done in transfer
  logic [7:0]  div_cnt;          // Half-period timer
  logic        burst_done;       // Last frame shifted out
  logic        starve;           // Needed frame, queue empty
  logic        enabled;

  assign enabled    = control[CTL_ENABLE];
  assign tx_pop     = (state == SFX_LOAD) & ~tx_queue_empty;
  assign starve     = (state == SFX_LOAD) & tx_queue_empty;
  assign burst_done = (state == SFX_SHIFT) && spi_clk && div_cnt == 8'h00 &&
                      bit_cnt == 6'h01 && frame_cnt + 16'h1 >= frames_per_transfer;
  assign rx_done    = (state == SFX_SHIFT) && spi_clk && div_cnt == 8'h00 &&
                      bit_cnt == 6'h01;

  // Shift state machine; sample on rising link edge, change on falling
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state     <= SFX_IDLE;
      shreg     <= 32'h0;
      rx_word   <= 32'h0;
      bit_cnt   <= 6'h00;
      frame_cnt <= 16'h0000;
      div_cnt   <= 8'h00;
      spi_clk   <= 1'b0;
    end
    else if (!enabled)
    begin
      state   <= SFX_IDLE;
      spi_clk <= 1'b0;
    end
    else
    begin
      unique case (state)
        SFX_IDLE:
        begin
          // Start a transfer once data is queued
          frame_cnt <= 16'h0000;
          if (!tx_queue_empty)
            state <= SFX_LOAD;
        end
        SFX_LOAD:
        begin
          if (tx_queue_empty)
            state <= SFX_IDLE;
          else
          begin
            shreg   <= txq[tx_rp[1:0]] << (6'd32 - frame_bit_width);
            // capture starts empty so no earlier bits leak in
            rx_word <= 32'h0;
            bit_cnt <= frame_bit_width;
            div_cnt <= clk_gen;
            state   <= SFX_SHIFT;
          end
        end
        SFX_SHIFT:
        begin
          if (div_cnt != 8'h00)
            div_cnt <= div_cnt - 8'h01;
          else
          begin
            div_cnt <= clk_gen;
            spi_clk <= ~spi_clk;
            if (!spi_clk)
              rx_word <= {rx_word[30:0], di_sync};
            else if (bit_cnt != 6'h01)
            begin
              shreg   <= {shreg[30:0], 1'b0};
              bit_cnt <= bit_cnt - 6'h01;
            end
            else
            begin
              // count frames, stop at programmed count
              frame_cnt <= frame_cnt + 16'h1;
              state     <= burst_done ? SFX_IDLE : SFX_LOAD;
            end
          end
        end
        default:
          state <= SFX_IDLE;
      endcase
    end
  end

  // output enable only inside a transfer
  assign spi_do             = shreg[31];
  assign spi_doe_n          = ~(state == SFX_SHIFT) | control[CTL_OENOFF];
  assign target_select_line = ~(slave_sel & enabled);

  // ----------------------------------------
  // Events and interrupt
  // ----------------------------------------
  // burst-sent at end of the burst
  assign irq_set[ST_SENT]   = burst_done;
  assign irq_set[ST_RCVD]   = rx_done & burst_done;
  assign irq_set[ST_SPILL]  = rx_done & rx_queue_full;
  assign irq_set[ST_STARVE] = starve;

  // Sticky flags; set wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      raw_irq_status <= 4'h0;
    else if (wr_en && hit(paddr, OFS_INT_CLEAR))
      raw_irq_status <= (raw_irq_status & ~pwdata[3:0]) | irq_set;
    else
      raw_irq_status <= raw_irq_status | irq_set;
  end

  logic [3:0] irq_mask;
  logic [3:0] mis;
  assign irq_mask = {control[CTL_IE_UND], control[CTL_IE_OVF],
                     control[CTL_IE_RX], control[CTL_IE_TX]};
  assign mis = raw_irq_status & irq_mask;
  assign fabric_irq_link = |mis;

  // ----------------------------------------
  // DMA requests
  // ----------------------------------------
  // data waiting; drops with last read
  assign dma_rx_ready_req = ~rx_queue_empty;
  // engine idle and room in queue
  assign dma_tx_space_req = (state == SFX_IDLE) & ~tx_queue_full;

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  logic [31:0] status;
  always_comb
  begin
    status            = 32'h0;
    status[3:0]       = raw_irq_status;
    status[ST_RXFULL] = rx_queue_full;
    status[ST_RXEMP]  = rx_queue_empty;
    status[ST_TXFULL] = tx_queue_full;
    status[ST_TXEMP]  = tx_queue_empty;
    status[ST_ACTIVE] = (state != SFX_IDLE);
  end

  always_comb
  begin
    unique case (paddr)
      OFS_CONTROL:   prdata = control;
      OFS_FRAMESIZE: prdata = {26'h0, frame_bit_width};
      OFS_STATUS:    prdata = status;
      OFS_RX_DATA:   prdata = rxq[rx_rp[1:0]];
      OFS_CLK_GEN:   prdata = {24'h0, clk_gen};
      OFS_SLAVE_SEL: prdata = {31'h0, slave_sel};
      OFS_MIS:       prdata = {28'h0, mis};
      OFS_RIS:       prdata = {28'h0, raw_irq_status};
      default:       prdata = 32'h0;
    endcase
  end
  // Unmapped offsets answer with an error
  assign pslverr = psel & penable & ~(hit(paddr, OFS_CONTROL) | hit(paddr, OFS_FRAMESIZE) |
                   hit(paddr, OFS_STATUS) | hit(paddr, OFS_INT_CLEAR) |
                   hit(paddr, OFS_RX_DATA) | hit(paddr, OFS_TX_DATA) |
                   hit(paddr, OFS_CLK_GEN) | hit(paddr, OFS_SLAVE_SEL) |
                   hit(paddr, OFS_MIS) | hit(paddr, OFS_RIS));

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  AST_QFULL: assert property (@(posedge pclk) disable iff (!presetn)
    tx_push && (tx_wp - tx_rp == 3'h3) && !tx_pop |=> tx_queue_full)
    else $error("tx queue not full after fourth entry");
  AST_FLAGS: assert property (@(posedge pclk) disable iff (!presetn)
    status[ST_TXEMP] == ((tx_wp - tx_rp) == 3'h0) &&
    status[ST_TXFULL] == ((tx_wp - tx_rp) == 3'h4))
    else $error("tx empty flag wrong");
  AST_SENT: assert property (@(posedge pclk) disable iff (!presetn)
    burst_done |=> raw_irq_status[ST_SENT])
    else $error("frames sent flag missing");
  AST_STARVE: assert property (@(posedge pclk) disable iff (!presetn)
    starve |=> state == SFX_IDLE && raw_irq_status[ST_STARVE])
    else $error("starve not handled");
  AST_SPILL: assert property (@(posedge pclk) disable iff (!presetn)
    rx_done && rx_queue_full && !rx_pop |=> $stable(rx_wp) && raw_irq_status[ST_SPILL])
    else $error("spill not handled");
  AST_WIDTH: assert property (@(posedge pclk) disable iff (!presetn)
    enabled && $past(enabled) |-> $stable(frame_bit_width))
    else $error("width changed while enabled");
  AST_RXREQ: assert property (@(posedge pclk) disable iff (!presetn)
    rx_pop && (rx_wp - rx_rp == 3'h1) && !rx_push |=> !dma_rx_ready_req)
    else $error("rx request stuck");
  AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
    fabric_irq_link == ((raw_irq_status[ST_SENT] & control[CTL_IE_TX]) |
                        (raw_irq_status[ST_RCVD] & control[CTL_IE_RX]) |
                        (raw_irq_status[ST_SPILL] & control[CTL_IE_OVF]) |
                        (raw_irq_status[ST_STARVE] & control[CTL_IE_UND])))
    else $error("irq merge wrong");
endmodule

// ===== core/sfx_pkg.sv
// Package: register map, field positions, reset values and states of the
// SPI transfer engine. Assumes an APB host with 32-bit data.
package sfx_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CONTROL   = 8'h00;
  localparam logic [7:0] OFS_FRAMESIZE = 8'h04;
  localparam logic [7:0] OFS_STATUS    = 8'h08;
  localparam logic [7:0] OFS_INT_CLEAR = 8'h0c;
  localparam logic [7:0] OFS_RX_DATA   = 8'h10;
  localparam logic [7:0] OFS_TX_DATA   = 8'h14;
  localparam logic [7:0] OFS_CLK_GEN   = 8'h18;
  localparam logic [7:0] OFS_SLAVE_SEL = 8'h1c;
  localparam logic [7:0] OFS_MIS       = 8'h20;
  localparam logic [7:0] OFS_RIS       = 8'h24;
  // Control field positions
  localparam int CTL_ENABLE = 0;
  localparam int CTL_MODE   = 1;
  localparam int CTL_IE_RX  = 4;
  localparam int CTL_IE_TX  = 5;
  localparam int CTL_IE_OVF = 6;
  localparam int CTL_IE_UND = 7;
  localparam int CTL_CNT_LO = 8;
  localparam int CTL_OENOFF = 30;
  // Status / interrupt bit positions
  localparam int ST_SENT   = 0;
  localparam int ST_RCVD   = 1;
  localparam int ST_SPILL  = 2;
  localparam int ST_STARVE = 3;
  localparam int ST_RXFULL = 4;
  localparam int ST_RXEMP  = 6;
  localparam int ST_TXFULL = 8;
  localparam int ST_TXEMP  = 10;
  localparam int ST_ACTIVE = 14;
  // Reset values and frame width limit
  localparam logic [15:0] RST_FRAME_COUNT = 16'h0001;
  localparam logic [5:0]  RST_FRAME_WIDTH = 6'h04;
  localparam logic [5:0]  MAX_FRAME_WIDTH = 6'h20;
  localparam logic [7:0]  RST_CLK_GEN     = 8'h07;
  localparam logic        RST_MODE        = 1'b1;
  // Queue geometry
  localparam int QDEPTH = 4;
  localparam int QWIDTH = 32;
  // Shift engine states
  typedef enum logic [1:0]
  {
    SFX_IDLE  = 2'b00,
    SFX_LOAD  = 2'b01,
    SFX_SHIFT = 2'b10
  } sfx_state_t;
endpackage

// ===== bench/sfx_slave_model.sv
// Behavioural SPI slave that stands in for a serial flash.
// Assumes mode 0 and an active-low select from the controller.
`timescale 1ns/100ps
module sfx_slave_model
#(
  parameter logic [31:0] REPLY = 32'h5ac3_96e1  // Answer pattern, rotated out
)
(
  // SPI pins
  input  wire logic spi_clk,
  input  wire logic spi_do,
  input  wire logic target_select_line,
  output logic      spi_di,
  // Observation for the bench
  output logic [31:0] cap_word,
  output int          bit_count
);
  logic [31:0] sr;  // Answer shifter
  initial
  begin
    sr = REPLY;
    cap_word = '0;
    bit_count = 0;
  end
  // Capture on rising edge while selected
  always @(posedge spi_clk)
    if (!target_select_line)
    begin
      cap_word <= {cap_word[30:0], spi_do};
      bit_count <= bit_count + 1;
    end
  // Next answer bit on falling edge, so it is stable at capture
  always @(negedge spi_clk)
    if (!target_select_line)
      sr <= {sr[30:0], sr[31]};
  // Released line shows the inverse of the last bit, never a held value
  assign spi_di = target_select_line ? ~sr[31] : sr[31];
endmodule

// ===== bench/tb_sfx_engine.sv
// Self-checking bench for the SPI transfer engine.
// Assumes zero-wait APB and the slave model on the SPI pins.
`timescale 1ns/100ps
module tb_sfx_engine;
  import sfx_pkg::*;
  localparam logic [31:0] REPLY = 32'h5ac3_96e1;  // Slave answer pattern
  // APB side
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, lerr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, d;
  // SPI and request side
  logic spi_clk, spi_do, spi_doe_n, spi_di, tsl, txq, rxq, irq;
  logic [31:0] cap;
  int bits, off, err_count, samples_checked, cyc;
  sfx_engine dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .spi_clk(spi_clk), .spi_do(spi_do), .spi_doe_n(spi_doe_n),
    .spi_di(spi_di), .target_select_line(tsl), .dma_tx_space_req(txq),
    .dma_rx_ready_req(rxq), .fabric_irq_link(irq));
  sfx_slave_model #(.REPLY(REPLY)) slave (.spi_clk(spi_clk), .spi_do(spi_do),
    .target_select_line(tsl), .spi_di(spi_di), .cap_word(cap), .bit_count(bits));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // One APB transfer; an idle edge first so strobes never toggle twice
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    d = prdata;
    lerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Poll a status bit with a bounded number of reads
  task automatic wait_bit(input int b);
    int n;
    n = 0;
    d = '0;
    while (d[b] !== 1'b1 && n < 600)
    begin
      apb(1'b0, OFS_STATUS, '0);
      n++;
    end
  endtask
  // Expected answer byte starting at a stream bit offset
  function automatic logic [7:0] ans(input int o);
    logic [31:0] r;
    r = (REPLY << (o % 32)) | (REPLY >> ((32 - o % 32) % 32));
    return r[31:24];
  endfunction
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    apb(1'b0, OFS_CONTROL, '0);
    chk("control", 32'h0000_0102, d);
    apb(1'b0, OFS_FRAMESIZE, '0);
    chk("width", 32'h0000_0004, d);
    apb(1'b0, OFS_STATUS, '0);
    chk("status", 32'h0000_0440, d);
    chk("reqs", 32'h2, {txq, rxq});
    chk("idle pins", 32'h6, {spi_clk, spi_do, spi_doe_n, tsl, irq});
    apb(1'b0, 8'h3c, '0);
    chk("unmapped", 32'h1, lerr);
  endtask
  task automatic t_width();
    apb(1'b1, OFS_CONTROL, 32'h0000_0103);
    apb(1'b1, OFS_FRAMESIZE, 32'h8);
    apb(1'b1, OFS_CLK_GEN, 32'h9);
    apb(1'b1, OFS_SLAVE_SEL, 32'h1);
    apb(1'b0, OFS_FRAMESIZE, '0);
    chk("width locked", 32'h4, d);
    apb(1'b1, OFS_CONTROL, 32'h0000_0102);
    apb(1'b1, OFS_FRAMESIZE, 32'h21);
    apb(1'b0, OFS_FRAMESIZE, '0);
    chk("width above 32", 32'h4, d);
    apb(1'b1, OFS_FRAMESIZE, 32'h8);
    apb(1'b0, OFS_FRAMESIZE, '0);
    chk("width set", 32'h8, d);
  endtask
  task automatic t_burst();
    apb(1'b1, OFS_CONTROL, 32'h0000_0422);
    for (int i = 0; i < 5; i++)
      apb(1'b1, OFS_TX_DATA, 32'h10 * i + 32'ha1);
    apb(1'b0, OFS_STATUS, '0);
    chk("tx full", 32'h1, d[ST_TXFULL]);
    chk("tx req full", 32'h0, txq);
    off = bits;
    apb(1'b1, OFS_CONTROL, 32'h0000_0423);
    wait_bit(ST_SENT);
    chk("sent irq", 32'h1, irq);
    chk("oe off", 32'h1, spi_doe_n);
    chk("bits", 32'd32, bits - off);
    chk("wire word", 32'ha1b1_c1d1, cap);
    apb(1'b0, OFS_STATUS, '0);
    chk("rx full", 32'h1, d[ST_RXFULL]);
    chk("reqs done", 32'h3, {txq, rxq});
  endtask
  task automatic t_spill();
    apb(1'b1, OFS_INT_CLEAR, 32'hf);
    apb(1'b1, OFS_CONTROL, 32'h0000_0142);
    apb(1'b1, OFS_CONTROL, 32'h0000_0143);
    apb(1'b1, OFS_TX_DATA, 32'h77);
    wait_bit(ST_SPILL);
    chk("spill irq", 32'h1, irq);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, OFS_RX_DATA, '0);
      chk("rx data", {24'h0, ans(off + 8 * i)}, d);
    end
    // Let the last pop settle before looking at the request
    @(negedge pclk);
    chk("rx req", 32'h0, rxq);
    apb(1'b0, OFS_STATUS, '0);
    chk("rx empty", 32'h1, d[ST_RXEMP]);
  endtask
  task automatic t_starve();
    apb(1'b1, OFS_INT_CLEAR, 32'hf);
    apb(1'b1, OFS_CONTROL, 32'h0000_0382);
    apb(1'b1, OFS_TX_DATA, 32'h3c);
    apb(1'b1, OFS_CONTROL, 32'h0000_0383);
    wait_bit(ST_STARVE);
    chk("starve irq", 32'h1, irq);
    chk("no sent", 32'h0, d[ST_SENT]);
    chk("idle oe", 32'h1, spi_doe_n);
    apb(1'b1, OFS_INT_CLEAR, 32'hf);
    @(negedge pclk);
    chk("irq cleared", 32'h0, irq);
    apb(1'b1, OFS_CONTROL, 32'h0000_0382);
    for (int i = 0; i < 3; i++)
      apb(1'b1, OFS_TX_DATA, 32'h10 * i + 32'h3c);
    off = bits;
    apb(1'b1, OFS_CONTROL, 32'h0000_0383);
    wait_bit(ST_SENT);
    chk("restart bits", 32'd24, bits - off);
    chk("restart word", 32'h003c_4c5c, {8'h0, cap[23:0]});
  endtask
  task automatic t_dma();
    int n;
    n = 0;
    while (rxq === 1'b1 && n < 8)
    begin
      apb(1'b0, OFS_RX_DATA, '0);
      @(negedge pclk);
      n++;
    end
    chk("dma drained", 32'h4, n);
    chk("rx req low", 32'h0, rxq);
    apb(1'b1, OFS_CONTROL, 32'h0000_0102);
    apb(1'b1, OFS_INT_CLEAR, 32'hf);
    apb(1'b1, OFS_TX_DATA, 32'h5a);
    off = bits;
    apb(1'b1, OFS_CONTROL, 32'h0000_0103);
    wait_bit(ST_SENT);
    chk("masked irq", 32'h0, irq);
    chk("dma reqs", 32'h3, {txq, rxq});
    apb(1'b0, OFS_RX_DATA, '0);
    chk("dma data", {24'h0, ans(off)}, d);
  endtask
  // One transfer of n bytes, low byte last on the wire
  task automatic xfer(input int n, input logic [31:0] w);
    logic [31:0] m;
    m = (n == 4) ? 32'hffff_ffff : ((32'h1 << (8 * n)) - 32'h1);
    apb(1'b1, OFS_CONTROL, {8'h00, n[15:0], 8'h02});
    apb(1'b1, OFS_FRAMESIZE, 32'h8);
    apb(1'b1, OFS_INT_CLEAR, 32'hf);
    for (int i = n - 1; i >= 0; i--)
      apb(1'b1, OFS_TX_DATA, {24'h0, w[8 * i +: 8]});
    apb(1'b1, OFS_CONTROL, {8'h00, n[15:0], 8'h03});
    wait_bit(ST_SENT);
    chk("flash bytes", w & m, cap & m);
    for (int i = 0; i < n; i++)
      apb(1'b0, OFS_RX_DATA, '0);
  endtask
  task automatic t_flash();
    apb(1'b1, OFS_SLAVE_SEL, 32'h1);
    xfer(1, 32'h06);
    xfer(4, 32'h3901_0000);
    xfer(1, 32'h06);
    xfer(4, 32'h0201_0000);
    xfer(2, 32'h5aa5);
    apb(1'b1, OFS_SLAVE_SEL, 32'h0);
    @(negedge pclk);
    chk("deselect", 32'h1, tsl);
    apb(1'b1, OFS_SLAVE_SEL, 32'h1);
    xfer(4, 32'h1b01_0000);
  endtask
  // ----------------------------------------
  // Verdict, clock, timeout, main sequence
  // ----------------------------------------
  task automatic stop_test();
    if (err_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    pclk = 1'b0;
    forever
      #4 pclk = ~pclk;
  end
  // Ceiling well above the few thousand cycles the scenarios need
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc > 50000)
    begin
      err_count++;
      stop_test();
    end
  end
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {err_count, samples_checked, cyc} = '0;
    repeat (20)
      @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_width();
    t_burst();
    t_spill();
    t_starve();
    t_dma();
    t_flash();
    stop_test();
  end
endmodule
